// *** hw/vic_pkg.sv ***
// package: constants, register map and carrier types of the interrupt controller
package vic_pkg;

  // geometry
  localparam int VIC_NUM_VEC   = 32;
  localparam int VIC_VEC_W     = 5;
  localparam int VIC_PRIO_W    = 3;
  localparam int VIC_NEST_MAX  = 8;
  localparam int VIC_DEPTH_W   = 4;
  localparam int VIC_ADDR_W    = 16;
  localparam int VIC_BUS_AW    = 10;
  localparam int VIC_DMA_A_W   = 16;
  localparam int VIC_DMA_B_W   = 15;

  // register byte offsets
  localparam logic [9:0] VIC_OFS_ENABLE  = 10'h000;
  localparam logic [9:0] VIC_OFS_PEND    = 10'h004;
  localparam logic [9:0] VIC_OFS_SETPEND = 10'h008;
  localparam logic [9:0] VIC_OFS_CLRPEND = 10'h00c;
  localparam logic [9:0] VIC_OFS_STATUS  = 10'h010;
  localparam logic [9:0] VIC_OFS_HANDLER = 10'h100;
  localparam logic [9:0] VIC_OFS_PRIOSEL = 10'h180;
  localparam logic [9:0] VIC_TABLE_MASK  = 10'h380;

  // field positions
  localparam int VIC_PRIO_LSB  = 0;
  localparam int VIC_SEL_LSB   = 4;
  localparam int VIC_ST_VEC    = 0;
  localparam int VIC_ST_REQ    = 7;
  localparam int VIC_ST_DEPTH  = 8;
  localparam int VIC_ST_RUNPRI = 12;

  // reset values
  localparam logic [31:0]           VIC_ENABLE_RST  = 32'h0000_0000;
  localparam logic [VIC_PRIO_W-1:0] VIC_PRIO_RST    = 3'h7;
  localparam logic [VIC_ADDR_W-1:0] VIC_HANDLER_RST = 16'h0000;
  // running level when no handler is active: below every priority
  localparam logic [3:0]            VIC_IDLE_LEVEL  = 4'h8;

  // vectors with no fixed-function source
  localparam logic [31:0] VIC_FIXED_NONE = 32'h8c00_0004;

  typedef enum logic [1:0] {
    VIC_SRC_FIXED = 2'h0,
    VIC_SRC_DMA   = 2'h1,
    VIC_SRC_ARRAY = 2'h2,
    VIC_SRC_NONE  = 2'h3
  } vic_src_sel_t;

  typedef struct packed {
    logic       hub_error;
    logic       decimator;
    logic       digital_filter_engine;
    logic [4:0] usb;
    logic [3:0] timer;
    logic       can;
    logic       i2c;
    logic       switched_caps;
    logic       comparators;
    logic [8:0] port_interrupt_unit;
    logic       sleep;
    logic       ecc;
    logic       low_voltage_detect;
  } vic_fixed_src_t;

  typedef struct packed {
    logic                  req;
    logic [VIC_VEC_W-1:0]  vector;
    logic [VIC_ADDR_W-1:0] addr;
  } vic_core_req_t;

endpackage

// *** hw/vic_top.sv ***
// vectored interrupt controller: sources, pending, arbitration, nesting
// Notes on behaviour
// - thirty-two vectors, each can raise its own request to the core
// - per-vector enable; a disabled vector is never forwarded
// - each vector has a run-time writable priority of eight levels
// - nesting to eight deep; strictly higher priority preempts a running one
// - software write sets a vector pending like a hardware source
// - software write clears a vector pending so it is not serviced
// - each vector has a programmable handler address given to the core
// - equal priority: lowest vector number is presented first
// - per-vector source select: fixed-function, DMA terminal or array
// - DMA: vectors 0-15 from group a, 16-30 from group b bits 0-14
// - array source for vector n is bit n of the array interrupt bus
// - array path lets any signal reach any vector
// - fixed-function sources map to their listed vectors; 2,26,27 reserved
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module vic_top
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  // avalon-mm slave
  input  wire logic [vic_pkg::VIC_BUS_AW-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // interrupt sources
  input  wire vic_pkg::vic_fixed_src_t       fixed_src,
  input  wire logic [vic_pkg::VIC_DMA_A_W-1:0] dma_terminal_out_group_a,
  input  wire logic [vic_pkg::VIC_DMA_B_W-1:0] dma_terminal_out_group_b,
  input  wire logic [vic_pkg::VIC_NUM_VEC-1:0] array_irq,
  // processor core side
  output vic_pkg::vic_core_req_t             core_out,
  input  wire logic                          core_irq_ack,
  input  wire logic                          core_irq_return
);
  import vic_pkg::*;

  logic [31:0]           enable_reg;
  logic [31:0]           pending_reg;
  logic [31:0]           pending_next;
  logic [31:0]           src_prev_reg;
  logic [31:0]           src_now;
  logic [31:0]           src_rise;
  logic [31:0]           pend_set;
  logic [31:0]           pend_clr;
  logic [31:0]           cand;
  logic [31:0]           fixed_vec;
  logic [31:0]           dma_vec;
  logic [31:0]           be_mask;
  logic [VIC_PRIO_W-1:0] prio_reg    [VIC_NUM_VEC];
  vic_src_sel_t          sel_reg     [VIC_NUM_VEC];
  logic [VIC_ADDR_W-1:0] handler_reg [VIC_NUM_VEC];
  logic [VIC_PRIO_W-1:0] stk_prio    [VIC_NEST_MAX];
  logic [VIC_DEPTH_W-1:0] depth_reg;
  logic [3:0]            run_level;
  logic                  best_found;
  logic [VIC_VEC_W-1:0]  best_vec;
  logic [VIC_PRIO_W-1:0] best_prio;
  logic                  grant_ok;
  logic                  ack_reg;
  logic                  bus_req;
  logic                  wr_acc;
  logic                  rd_cap;
  logic [31:0]           rd_data;
  logic [VIC_VEC_W-1:0]  idx;
  logic                  in_handler;
  logic                  in_priosel;
  logic                  take;
  logic                  pop;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
      m[b*8 +: 8] = {8{be[b]}};
    return m;
  endfunction

  // bus slave: one wait cycle, then the access completes
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign wr_acc          = avs_write & ack_reg;
  assign rd_cap          = avs_read & ~ack_reg;
  assign be_mask         = lane_mask(avs_byteenable);
  assign idx             = avs_address[6:2];
  assign in_handler = (avs_address & VIC_TABLE_MASK) == VIC_OFS_HANDLER;
  assign in_priosel = (avs_address & VIC_TABLE_MASK) == VIC_OFS_PRIOSEL;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & ~ack_reg;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (in_handler)
      rd_data[VIC_ADDR_W-1:0] = handler_reg[idx];
    else if (in_priosel)
    begin
      rd_data[VIC_PRIO_LSB +: VIC_PRIO_W] = prio_reg[idx];
      rd_data[VIC_SEL_LSB +: 2] = sel_reg[idx];
    end
    else
      unique case ({avs_address[9:2], 2'b00})
        VIC_OFS_ENABLE:  rd_data = enable_reg;
        VIC_OFS_PEND:    rd_data = pending_reg;
        VIC_OFS_STATUS:
        begin
          rd_data[VIC_ST_VEC +: VIC_VEC_W] = core_out.vector;
          rd_data[VIC_ST_REQ] = core_out.req;
          rd_data[VIC_ST_DEPTH +: VIC_DEPTH_W] = depth_reg;
          rd_data[VIC_ST_RUNPRI +: 4] = run_level;
        end
        default:         rd_data = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if (rd_cap)
      avs_readdata <= rd_data;
  end

  // enable register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_reg <= VIC_ENABLE_RST;
    else if (wr_acc && {avs_address[9:2], 2'b00} == VIC_OFS_ENABLE)
      enable_reg <= (enable_reg & ~be_mask) | (avs_writedata & be_mask);
  end

  // per-vector tables
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < VIC_NUM_VEC; i++)
      begin
        prio_reg[i]    <= VIC_PRIO_RST;
        sel_reg[i]     <= VIC_SRC_FIXED;
        handler_reg[i] <= VIC_HANDLER_RST;
      end
    end
    else if (wr_acc)
    begin
      if (in_handler)
      begin
        if (avs_byteenable[0])
          handler_reg[idx][7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1])
          handler_reg[idx][15:8] <= avs_writedata[15:8];
      end
      if (in_priosel && avs_byteenable[0])
      begin
        prio_reg[idx] <= avs_writedata[VIC_PRIO_LSB +: VIC_PRIO_W];
        sel_reg[idx]  <= vic_src_sel_t'(avs_writedata[VIC_SEL_LSB +: 2]);
      end
    end
  end

  // source routing
  assign fixed_vec = {1'b0, fixed_src.hub_error, fixed_src.decimator,
                      fixed_src.digital_filter_engine, 2'b00, fixed_src.usb,
                      fixed_src.timer, fixed_src.can, fixed_src.i2c,
                      fixed_src.switched_caps, fixed_src.comparators,
                      fixed_src.port_interrupt_unit, fixed_src.sleep, 1'b0,
                      fixed_src.ecc, fixed_src.low_voltage_detect};
  assign dma_vec = {1'b0, dma_terminal_out_group_b,
                    dma_terminal_out_group_a};

  always_comb
  begin
    for (int i = 0; i < VIC_NUM_VEC; i++)
      unique case (sel_reg[i])
        VIC_SRC_FIXED: src_now[i] = fixed_vec[i];
        VIC_SRC_DMA:   src_now[i] = dma_vec[i];
        VIC_SRC_ARRAY: src_now[i] = array_irq[i];
        VIC_SRC_NONE:  src_now[i] = 1'b0;
      endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      src_prev_reg <= 32'h0000_0000;
    else
      src_prev_reg <= src_now;
  end

  // pending: set wins over clear
  assign src_rise = src_now & ~src_prev_reg;
  assign take     = core_irq_ack & core_out.req;
  assign pop      = core_irq_return & (depth_reg != '0);

  always_comb
  begin
    pend_set = src_rise;
    pend_clr = 32'h0000_0000;
    if (wr_acc && {avs_address[9:2], 2'b00} == VIC_OFS_SETPEND)
      pend_set = pend_set | (avs_writedata & be_mask);
    if (wr_acc && {avs_address[9:2], 2'b00} == VIC_OFS_CLRPEND)
      pend_clr = avs_writedata & be_mask;
    if (take)
      pend_clr[core_out.vector] = 1'b1;
    pending_next = (pending_reg & ~pend_clr) | pend_set;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pending_reg <= 32'h0000_0000;
    else
      pending_reg <= pending_next;
  end

  // arbitration: best priority, lowest number on a tie
  assign cand = pending_reg & enable_reg;

  always_comb
  begin
    best_found = 1'b0;
    best_vec   = '0;
    best_prio  = '1;
    for (int i = VIC_NUM_VEC - 1; i >= 0; i--)
      if (cand[i] && (!best_found || prio_reg[i] <= best_prio))
      begin
        best_found = 1'b1;
        best_vec   = VIC_VEC_W'(i);
        best_prio  = prio_reg[i];
      end
  end

  assign run_level = (depth_reg == '0) ? VIC_IDLE_LEVEL
                   : {1'b0, stk_prio[3'(depth_reg - 4'h1)]};
  assign grant_ok = best_found && (depth_reg < VIC_DEPTH_W'(VIC_NEST_MAX))
                  && ({1'b0, best_prio} < run_level);

  // request to the core, held off the cycle after it is taken or returned
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      core_out <= '0;
    else
    begin
      core_out.req    <= grant_ok & ~core_irq_ack & ~core_irq_return;
      core_out.vector <= best_vec;
      core_out.addr   <= handler_reg[best_vec];
    end
  end

  // nesting stack of running priorities
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      depth_reg <= '0;
      for (int i = 0; i < VIC_NEST_MAX; i++)
        stk_prio[i] <= '0;
    end
    else
      unique case ({take, pop})
        2'b10:
        begin
          stk_prio[3'(depth_reg)] <= prio_reg[core_out.vector];
          depth_reg <= depth_reg + 4'h1;
        end
        2'b01:
          depth_reg <= depth_reg - 4'h1;
        2'b11:
          stk_prio[3'(depth_reg - 4'h1)] <= prio_reg[core_out.vector];
        2'b00: ;
      endcase
  end

  // assertion helpers
  logic [31:0] enable_q;
  logic [31:0] pending_q;
  logic [3:0]  run_level_q;
  logic        wr_handler;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable_q    <= '0;
      pending_q   <= '0;
      run_level_q <= VIC_IDLE_LEVEL;
    end
    else
    begin
      enable_q    <= enable_reg;
      pending_q   <= pending_reg;
      run_level_q <= run_level;
    end
  end

  assign wr_handler = wr_acc & in_handler;

  function automatic logic tie_clean(input logic [31:0] c,
                                     input logic [VIC_VEC_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < VIC_NUM_VEC; i++)
      if (c[i] && VIC_VEC_W'(i) < v && prio_reg[i] == prio_reg[v])
        ok = 1'b0;
    return ok;
  endfunction

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_disabled_no_req: assert property (
    core_out.req |-> enable_q[core_out.vector])
    else $error("request shown for a disabled vector");
  a_req_is_pending: assert property (
    core_out.req |-> pending_q[core_out.vector])
    else $error("request shown for a vector not pending");
  a_preempt_higher: assert property (
    core_out.req |-> ({1'b0, prio_reg[core_out.vector]} < run_level_q
                      && depth_reg < 4'h8))
    else $error("request does not outrank running level");
  a_tie_lowest: assert property (
    (core_out.req && $stable(enable_reg) && $stable(pending_reg))
      |-> tie_clean(cand, core_out.vector))
    else $error("equal priority vector with lower number skipped");
  a_sw_set_pend: assert property (
    (wr_acc && {avs_address[9:2], 2'b00} == VIC_OFS_SETPEND)
      |=> ((pending_reg & $past(avs_writedata & be_mask))
           == $past(avs_writedata & be_mask)))
    else $error("software set did not reach pending");
  a_sw_clr_pend: assert property (
    (wr_acc && {avs_address[9:2], 2'b00} == VIC_OFS_CLRPEND)
      |=> ((pending_reg & $past(avs_writedata & be_mask & ~pend_set)) == '0))
    else $error("software clear left a vector pending");
  a_src_sets_pend: assert property (
    (src_rise != '0) |=> ((pending_reg & $past(src_rise)) == $past(src_rise)))
    else $error("source edge did not set pending");
  a_handler_addr: assert property (
    (core_out.req && !$past(wr_handler))
      |-> core_out.addr == handler_reg[core_out.vector])
    else $error("presented address differs from handler table");
  a_take_push: assert property (
    (take && !core_irq_return) |=> depth_reg == $past(depth_reg) + 4'h1)
    else $error("taking a vector did not open a nesting level");
  a_return_pop: assert property (
    (pop && !take) |=> (depth_reg == $past(depth_reg) - 4'h1)
      && !core_out.req)
    else $error("return did not close a nesting level");

  c_nest_two: cover property (take ##[1:40] take);
  c_preempt: cover property (take && depth_reg == 4'h1);
  c_tie_two: cover property (core_out.req && $countones(cand) > 1);
  c_return: cover property (pop ##1 depth_reg == '0);

endmodule

`default_nettype wire

// *** testbench/vic_core_model.sv ***
// core model: takes presented vectors and returns from handlers
`timescale 1ns/10ps
`default_nettype none

module vic_core_model
  import vic_pkg::*;
(
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // controller side
  input  wire vic_pkg::vic_core_req_t      core_out,
  output logic                             core_irq_ack,
  output logic                             core_irq_return,
  // bench control and view
  input  wire logic                        take_en,
  input  wire logic                        finish,
  output logic [vic_pkg::VIC_VEC_W-1:0]    last_vec,
  output logic [vic_pkg::VIC_ADDR_W-1:0]   last_addr,
  output logic [vic_pkg::VIC_DEPTH_W-1:0]  depth
);
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_irq_ack    <= 1'b0;
      core_irq_return <= 1'b0;
      last_vec        <= '0;
      last_addr       <= '0;
      depth           <= '0;
    end
    else
    begin
      core_irq_ack    <= 1'b0;
      core_irq_return <= 1'b0;
      // one take per request; never during its own pulse
      if (take_en && core_out.req && !core_irq_ack && !core_irq_return)
      begin
        core_irq_ack <= 1'b1;
        last_vec     <= core_out.vector;
        last_addr    <= core_out.addr;
        depth        <= depth + 1'b1;
      end
      else if (finish && depth != '0)
      begin
        core_irq_return <= 1'b1;
        depth           <= depth - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench/vic_top_tb_top.sv ***
// testbench for the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none

module vic_top_tb_top;
  import vic_pkg::*;
  logic          sys_clk;
  logic          rst_n;
  logic [9:0]    avs_address;
  logic          avs_read;
  logic          avs_write;
  logic [31:0]   avs_writedata;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  logic [31:0]   q;
  logic [27:0]   fix_w;
  logic [31:0]   arr;
  logic [15:0]   dma_a;
  logic [14:0]   dma_b;
  vic_core_req_t core_out;
  logic          ack;
  logic          ret;
  logic          take_en;
  logic          finish;
  logic [4:0]    last_vec;
  logic [15:0]   last_addr;
  logic [3:0]    depth;
  logic [15:0]   hnd [32];
  logic [2:0]    m;
  int            seed = 8887;
  int            fails = 0;
  int            checked = 0;
  int            cyc = 0;
  int            v;
  int            s;

  vic_top vic_top_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fixed_src(vic_fixed_src_t'(fix_w)),
    .dma_terminal_out_group_a(dma_a), .dma_terminal_out_group_b(dma_b),
    .array_irq(arr), .core_out(core_out), .core_irq_ack(ack),
    .core_irq_return(ret));

  vic_core_model vic_core_model_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .core_out(core_out),
    .core_irq_ack(ack), .core_irq_return(ret), .take_en(take_en),
    .finish(finish), .last_vec(last_vec), .last_addr(last_addr),
    .depth(depth));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // fixed-function bit carrying vector n, none for reserved ones
  function automatic logic [27:0] fixed_bits(input int n);
    if (n == 2 || n == 26 || n == 27 || n > 30)
      return '0;
    return 28'h1 << (n < 2 ? n : (n < 26 ? n - 1 : n - 3));
  endfunction

  function automatic logic [31:0] exp_pend(input int k, input int n,
                                           input logic [2:0] mk);
    if (k > 2 || !mk[k])
      return '0;
    return (k == 0 && fixed_bits(n) == '0) ? '0 : 32'h1 << n;
  endfunction

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic take_one(input int tv, input int d);
    int n;
    n = 0;
    @(posedge sys_clk);
    take_en <= 1'b1;
    while (depth !== 4'(d) && n < 40)
    begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    take_en <= 1'b0;
    chk("nesting depth", 32'(d), 32'(depth));
    chk("taken vector", 32'(tv), 32'(last_vec));
    chk("handler address", 32'(hnd[tv]), 32'(last_addr));
  endtask

  task automatic ret_one();
    @(posedge sys_clk);
    finish <= 1'b1;
    @(posedge sys_clk);
    finish <= 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  task automatic see_req(input logic r, input int tv);
    repeat (4) @(negedge sys_clk);
    chk("request", 32'(r), 32'(core_out.req));
    if (r)
      chk("vector", 32'(tv), 32'(core_out.vector));
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  initial
  begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {fix_w, dma_a, dma_b, arr, take_en, finish} = '0;
    rst_n = 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    bus(0, VIC_OFS_STATUS, 0);
    chk("status", 32'h0000_8000, q);
    bus(1, 10'h020, 32'hffff_ffff);
    bus(0, 10'h020, 0);
    chk("unmapped", 0, q);
    for (v = 0; v < 32; v++)
    begin
      bus(0, VIC_OFS_PRIOSEL + 10'(4 * v), 0);
      chk("priority reset", 32'h7, q);
      bus(0, VIC_OFS_HANDLER + 10'(4 * v), 0);
      chk("handler reset", 0, q);
      hnd[v] = 16'($random(seed));
      bus(1, VIC_OFS_HANDLER + 10'(4 * v), {16'h0, hnd[v]});
      bus(0, VIC_OFS_HANDLER + 10'(4 * v), 0);
      chk("handler", {16'h0, hnd[v]}, q);
    end
    // disabled vector still latches but is not forwarded
    bus(1, VIC_OFS_SETPEND, 32'h40);
    bus(0, VIC_OFS_PEND, 0);
    chk("pending", 32'h40, q);
    see_req(0, 0);
    bus(1, VIC_OFS_ENABLE, 32'h40);
    see_req(1, 6);
    bus(1, VIC_OFS_CLRPEND, 32'h40);
    see_req(0, 0);
    bus(1, VIC_OFS_ENABLE, 32'hffff_ffff);
    // equal priority tie, then preemption by a stricter one
    bus(1, VIC_OFS_PRIOSEL + 10'(36), 32'h3);
    bus(1, VIC_OFS_PRIOSEL + 10'(80), 32'h3);
    bus(1, VIC_OFS_SETPEND, 32'h0010_0220);
    bus(0, VIC_OFS_PEND, 0);
    chk("pending", 32'h0010_0220, q);
    see_req(1, 9);
    chk("address", 32'(hnd[9]), 32'(core_out.addr));
    take_one(9, 1);
    see_req(0, 0);
    bus(1, VIC_OFS_PRIOSEL + 10'(4), 32'h0);
    bus(1, VIC_OFS_SETPEND, 32'h2);
    see_req(1, 1);
    take_one(1, 2);
    ret_one();
    ret_one();
    see_req(1, 20);
    bus(1, VIC_OFS_CLRPEND, 32'h0010_0020);
    see_req(0, 0);
    bus(0, VIC_OFS_PEND, 0);
    chk("pending", 0, q);
    // nest eight deep with rising priority
    for (v = 0; v < 8; v++)
    begin
      bus(1, VIC_OFS_PRIOSEL + 10'(4 * (10 + v)), 32'(7 - v));
      bus(1, VIC_OFS_SETPEND, 32'h1 << (10 + v));
      take_one(10 + v, v + 1);
    end
    bus(0, VIC_OFS_STATUS, 0);
    chk("depth and level", 32'h08, 32'(q[15:8]));
    bus(1, VIC_OFS_SETPEND, 32'h1);
    for (v = 0; v < 8; v++)
      ret_one();
    see_req(1, 0);
    bus(1, VIC_OFS_CLRPEND, 32'hffff_ffff);
    // source selection with random vectors and masks
    bus(1, VIC_OFS_ENABLE, 0);
    for (int t = 0; t < 40; t++)
    begin
      v = $unsigned($random(seed)) % 31;
      s = t % 4;
      m = 3'($random(seed));
      bus(1, VIC_OFS_PRIOSEL + 10'(4 * v), 32'(s << 4) | 32'h7);
      @(posedge sys_clk);
      fix_w <= m[0] ? fixed_bits(v) : '0;
      {dma_b, dma_a} <= m[1] ? 31'(32'h1 << v) : '0;
      arr <= m[2] ? 32'h1 << v : '0;
      @(posedge sys_clk);
      {fix_w, dma_b, dma_a, arr} <= '0;
      repeat (3) @(posedge sys_clk);
      bus(0, VIC_OFS_PEND, 0);
      chk("source pend", exp_pend(s, v, m), q);
      bus(1, VIC_OFS_CLRPEND, 32'hffff_ffff);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
